// ===== rtl/phy_reset_powerdown_sequencer.sv
`timescale 1ns/10ps
`include "phy_reset_defs.svh"

module phy_reset_powerdown_sequencer
  import phy_reset_pkg::*;
#(
  parameter int POR_CYCLES     = `POR_HOLD_CYCLES,
  parameter int RELEASE_CYCLES = `RELEASE_MAX_CYCLES,
  parameter int EXIT_EDGES     = `EXIT_REF_EDGES,
  parameter int SW_EDGES       = `SW_RESET_REF_EDGES
)(
  // Clock and power-on reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             supply_ok,
  // Reference clock, sampled
  input  wire logic             ref_clk_in,
  // Reset pin and address straps
  input  wire logic             hard_reset_pin_low_active,
  input  wire logic [4:0]       addr_strap,
  // Management writes to control bits
  input  wire logic             sw_reset_write,
  input  wire logic             power_down_write,
  input  wire logic             power_down_wdata,
  // Latching status sources and read strobe
  input  wire latch_status_type status_live,
  input  wire logic             status_read,
  // Transmit and receive clock loops
  input  wire logic             tx_clk_valid,
  input  wire logic             rx_clk_valid,
  // Register views
  output logic [15:0]           ctrl_reg,
  output logic [15:0]           ext_ctrl_reg,
  output latch_status_type      status_latched,
  // Pin and module controls
  output logic                  mac_inputs_isolate,
  output logic                  mac_outputs_enable,
  output logic                  line_transmit_enable,
  output logic                  modules_enable,
  output logic                  power_down,
  output logic                  defaults_load,
  output logic                  pll_resync,
  // Progress
  output logic                  mgmt_ready,
  output logic                  mii_ready
);

  localparam int TW = $clog2(POR_CYCLES + 1);
  localparam int RW = $clog2(EXIT_EDGES + 1);
  localparam logic [TW-1:0] POR_LAST = TW'(POR_CYCLES - 1);
  localparam logic [TW-1:0] REL_LAST = TW'(RELEASE_CYCLES - 1);
  localparam logic [RW-1:0] EXIT_LAST = RW'(EXIT_EDGES - 1);
  localparam logic [RW-1:0] SW_LAST = RW'(SW_EDGES - 1);

  // Refuse counts the counters cannot serve
  // Timer width follows the hold, so the release bound must fit in it
  if (POR_CYCLES < 1 || RELEASE_CYCLES < 1 ||
      RELEASE_CYCLES > POR_CYCLES ||
      SW_EDGES < 1 || SW_EDGES > EXIT_EDGES) begin : g_bad_param
    $error("phy_reset_powerdown_sequencer: bad count parameter");
  end

  seq_state_type    st;
  seq_state_type    next_st;
  logic [TW-1:0]    tmr;
  logic [RW-1:0]    ref_cnt;
  logic             ref_q;
  logic             ref_rise;
  logic             sw_bit;
  logic             pd_bit;
  logic             next_pd_bit;
  logic [4:0]       phy_addr;
  logic             from_sw;
  logic             entering;
  logic             in_reset;
  logic             next_hard;
  logic             next_active;
  logic             release_now;

  // Pins are synchronous, so one stage suffices for the edge
  // Reference must run below half of clk or rises are lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_clk_in;
    end
  end

  assign ref_rise = ref_clk_in & ~ref_q;

  assign entering = (next_st != st);
  assign in_reset = (st == ST_POR) || (st == ST_HW) || (st == ST_SW);
  assign next_hard = (next_st == ST_POR) || (next_st == ST_HW);
  assign next_active = (next_st == ST_EXIT) || (next_st == ST_RUN);

  // Release on sixteen reference edges or the 640 ns bound, first wins
  assign release_now = ((ref_cnt == EXIT_LAST) && ref_rise) ||
                       (tmr == REL_LAST);

  always_comb begin
    next_st = st;
    case (st)
      ST_POR: begin
        // Pin not looked at while power-on reset runs
        if (supply_ok && tmr == POR_LAST) begin
          next_st = ST_EXIT;
        end
      end
      ST_HW: begin
        if (hard_reset_pin_low_active) begin
          next_st = ST_EXIT;
        end
      end
      ST_SW: begin
        // Pin low overrides the software hold
        if (!hard_reset_pin_low_active) begin
          next_st = ST_HW;
        end else if (ref_rise && ref_cnt == SW_LAST) begin
          next_st = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (!hard_reset_pin_low_active) begin
          next_st = ST_HW;
        end else if (release_now) begin
          next_st = ST_RUN;
        end
      end
      ST_RUN: begin
        // Device relies on the pin being held low long enough
        if (!hard_reset_pin_low_active) begin
          next_st = ST_HW;
        end else if (sw_reset_write) begin
          next_st = ST_SW;
        end
      end
      default: begin
        next_st = ST_HW;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_POR;
    end else begin
      st <= next_st;
    end
  end

  // Cycle timer for power-on hold and release bound
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr <= '0;
    end else if (entering) begin
      tmr <= '0;
    end else if ((st == ST_POR && supply_ok) || st == ST_EXIT) begin
      tmr <= tmr + 1'b1;
    end
  end

  // Reference edge counter for software hold and exit steps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_cnt <= '0;
    end else if (entering) begin
      ref_cnt <= '0;
    end else if ((st == ST_SW || st == ST_EXIT) && ref_rise &&
                 ref_cnt != EXIT_LAST) begin
      ref_cnt <= ref_cnt + 1'b1;
    end
  end

  // Which kind of reset is being left
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      from_sw <= 1'b0;
    end else if (entering && next_st == ST_SW) begin
      from_sw <= 1'b1;
    end else if (entering && next_hard) begin
      from_sw <= 1'b0;
    end
  end

  // Software reset bit: only a management write sets it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_bit <= `SW_RESET_RST;
    end else if (st == ST_RUN && sw_reset_write &&
                 hard_reset_pin_low_active) begin
      sw_bit <= 1'b1;
    end else if (next_hard) begin
      sw_bit <= `SW_RESET_RST;
    end else if (entering && next_st == ST_EXIT) begin
      sw_bit <= `SW_RESET_RST;
    end
  end

  // Power-down bit, writable once management is ready
  always_comb begin
    next_pd_bit = pd_bit;
    if (in_reset || next_st == ST_POR || next_st == ST_HW ||
        next_st == ST_SW) begin
      next_pd_bit = `POWER_DOWN_RST;
    end else if (power_down_write && mgmt_ready) begin
      next_pd_bit = power_down_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_bit <= `POWER_DOWN_RST;
    end else begin
      pd_bit <= next_pd_bit;
    end
  end

  // Address captured only when leaving hardware or power-on reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phy_addr <= `PHY_ADDR_RST;
    end else if (entering && next_st == ST_EXIT && !from_sw &&
                 st != ST_SW) begin
      phy_addr <= addr_strap;
    end
  end

  assign ctrl_reg = {sw_bit, 3'h0, pd_bit, 11'h000};
  assign ext_ctrl_reg = {5'h00, phy_addr, 6'h00};

  // Latching status bits; an event in the read cycle is kept
  // Held at defaults all through power-down
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_latched.latch_low_status_bit     <= `LATCH_LOW_RST;
      status_latched.latch_high_status_bit    <= `LATCH_HIGH_RST;
      status_latched.latch_maximum_status_bit <= `LATCH_MAX_RST;
    end else if (in_reset || !next_active || next_pd_bit) begin
      status_latched.latch_low_status_bit     <= `LATCH_LOW_RST;
      status_latched.latch_high_status_bit    <= `LATCH_HIGH_RST;
      status_latched.latch_maximum_status_bit <= `LATCH_MAX_RST;
    end else begin
      status_latched.latch_low_status_bit <=
        status_live.latch_low_status_bit &
        (status_latched.latch_low_status_bit | status_read);
      status_latched.latch_high_status_bit <=
        status_live.latch_high_status_bit |
        (status_latched.latch_high_status_bit & ~status_read);
      if (status_read ||
          status_live.latch_maximum_status_bit >
          status_latched.latch_maximum_status_bit) begin
        status_latched.latch_maximum_status_bit <=
          status_live.latch_maximum_status_bit;
      end
    end
  end

  // Power-down: hard reset states or the control bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      power_down <= 1'b1;
    end else begin
      // Software reset deliberately stays out of power-down
      power_down <= next_hard || next_pd_bit;
    end
  end

  // Internal modules and line driver follow exit step order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      modules_enable       <= 1'b0;
      line_transmit_enable <= 1'b0;
    end else begin
      modules_enable       <= next_active && !next_pd_bit;
      line_transmit_enable <= next_active && !next_pd_bit;
    end
  end

  // MAC side released last, outputs off and inputs isolated while in power-down
  // Comes after the line driver so the MAC never sees a dead link
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mac_outputs_enable <= 1'b0;
      mac_inputs_isolate <= 1'b1;
    end else begin
      mac_outputs_enable <= (next_st == ST_RUN) && !next_pd_bit;
      mac_inputs_isolate <= !((next_st == ST_RUN) && !next_pd_bit);
    end
  end

  // One-cycle pulses for default load and loop resync
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      defaults_load <= 1'b0;
      pll_resync    <= 1'b0;
    end else begin
      defaults_load <= entering && next_st == ST_EXIT;
      pll_resync    <= (st == ST_EXIT) && (tmr == '0) && !entering;
    end
  end

  // Management usable once the first exit steps are done
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mgmt_ready <= 1'b0;
    end else begin
      mgmt_ready <= next_active && !(entering && next_st == ST_EXIT);
    end
  end

  // Data interface usable only with both clocks valid
  // Management may already run long before this rises
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mii_ready <= 1'b0;
    end else begin
      mii_ready <= (next_st == ST_RUN) && tx_clk_valid && rx_clk_valid &&
                   !next_pd_bit;
    end
  end

endmodule

// ===== rtl/phy_reset_defs.svh
`ifndef PHY_RESET_DEFS_SVH
`define PHY_RESET_DEFS_SVH

// Clock rate of the sequencer
`define CLK_PERIOD_NS        8

// Power-on hold, a least time: rounded up
`define POR_HOLD_NS          20000
`define POR_HOLD_CYCLES      ((`POR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// MAC pin release after reset removal, a longest time: rounded down
`define RELEASE_MAX_NS       640
`define RELEASE_MAX_CYCLES   (`RELEASE_MAX_NS / `CLK_PERIOD_NS)

// Reference clock edge counts
`define EXIT_REF_EDGES       16
`define SW_RESET_REF_EDGES   2
`define HW_RESET_MIN_EDGES   5

// Control register fields
`define CTRL_SW_RESET_BIT    15
`define CTRL_POWER_DOWN_BIT  11

// Extended control register address field
`define EXT_ADDR_MSB         10
`define EXT_ADDR_LSB         6

// Reset values
`define SW_RESET_RST         1'b0
`define POWER_DOWN_RST       1'b0
`define PHY_ADDR_RST         5'h00
`define LATCH_LOW_RST        1'b1
`define LATCH_HIGH_RST       1'b0
`define LATCH_MAX_RST        4'h0

`endif

// ===== rtl/phy_reset_pkg.sv
package phy_reset_pkg;

  typedef enum logic [4:0] {
    ST_POR  = 5'h01,
    ST_HW   = 5'h02,
    ST_SW   = 5'h04,
    ST_EXIT = 5'h08,
    ST_RUN  = 5'h10
  } seq_state_type;

  // Latching status bits and their live sources share one shape
  typedef struct packed {
    logic       latch_low_status_bit;
    logic       latch_high_status_bit;
    logic [3:0] latch_maximum_status_bit;
  } latch_status_type;

endpackage

// ===== verif/phy_reset_monitor.sv
`timescale 1ns/10ps
module phy_reset_monitor
  import phy_reset_pkg::*;
(
  // Clock and reset
  input wire logic             clk,
  input wire logic             arst_n,
  // Watched inputs
  input wire logic             hard_reset_pin_low_active,
  input wire logic             tx_clk_valid,
  input wire logic             rx_clk_valid,
  // Watched outputs
  input wire logic [15:0]      ctrl_reg,
  input wire logic [15:0]      ext_ctrl_reg,
  input wire latch_status_type status_latched,
  input wire logic             mac_inputs_isolate,
  input wire logic             mac_outputs_enable,
  input wire logic             line_transmit_enable,
  input wire logic             modules_enable,
  input wire logic             power_down,
  input wire logic             defaults_load,
  input wire logic             pll_resync,
  input wire logic             mgmt_ready,
  input wire logic             mii_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_entry;
    !hard_reset_pin_low_active |=> power_down && mac_inputs_isolate &&
      !mac_outputs_enable && !line_transmit_enable && !modules_enable;
  endproperty
  a_entry: assert property (p_entry)
    else $error("reset entry outputs wrong");
  property p_ready;
    $rose(mgmt_ready) |->
      $past(defaults_load) && modules_enable && line_transmit_enable;
  endproperty
  a_ready: assert property (p_ready)
    else $error("management ready out of order");
  property p_release;
    defaults_load |-> ##[1:80] (mac_outputs_enable && !mac_inputs_isolate);
  endproperty
  a_release: assert property (p_release)
    else $error("MAC pins not released in time");
  // Long low only: short glitches may fall in the power-on hold
  property p_hw16;
    $rose(hard_reset_pin_low_active) &&
      $past(hard_reset_pin_low_active, 20) == 1'b0 |-> ##[1:80] mgmt_ready;
  endproperty
  a_hw16: assert property (p_hw16)
    else $error("management late after pin release");
  property p_no_pd;
    ctrl_reg[15] |-> !power_down;
  endproperty
  a_no_pd: assert property (p_no_pd)
    else $error("power-down during software reset");
  property p_sw_done;
    $fell(ctrl_reg[15]) |-> defaults_load;
  endproperty
  a_sw_done: assert property (p_sw_done)
    else $error("software bit cleared without defaults");
  property p_hw_bit;
    !hard_reset_pin_low_active |=> !ctrl_reg[15];
  endproperty
  a_hw_bit: assert property (p_hw_bit)
    else $error("software bit set by pin reset");
  property p_addr;
    ctrl_reg[15] || $past(ctrl_reg[15]) |-> $stable(ext_ctrl_reg);
  endproperty
  a_addr: assert property (p_addr)
    else $error("address changed by software reset");
  property p_pd_bit;
    $rose(ctrl_reg[11]) |-> ##[0:1]
      (power_down && mgmt_ready && !line_transmit_enable);
  endproperty
  a_pd_bit: assert property (p_pd_bit)
    else $error("power-down bit not honoured");
  property p_latch;
    power_down && $past(power_down) |-> status_latched == 6'h20;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latching bits kept in power-down");
  property p_mii;
    mii_ready |-> $past(tx_clk_valid) && $past(rx_clk_valid);
  endproperty
  a_mii: assert property (p_mii)
    else $error("MII ready before clocks valid");
  property p_resync;
    $rose(mgmt_ready) |-> pll_resync;
  endproperty
  a_resync: assert property (p_resync)
    else $error("loop resync missing at management ready");
  c_sw: cover property ($fell(ctrl_reg[15]));
  c_pd: cover property ($rose(ctrl_reg[11]));
  c_mii: cover property ($rose(mii_ready));
endmodule

bind phy_reset_powerdown_sequencer phy_reset_monitor u_mon (
  .clk, .arst_n, .hard_reset_pin_low_active, .tx_clk_valid, .rx_clk_valid,
  .ctrl_reg, .ext_ctrl_reg, .status_latched, .mac_inputs_isolate,
  .mac_outputs_enable, .line_transmit_enable, .modules_enable, .power_down,
  .defaults_load, .pll_resync, .mgmt_ready, .mii_ready
);

// ===== verif/phy_far_side_model.sv
`timescale 1ns/10ps
module phy_far_side_model #(
  parameter int LOCK_CYCLES = 40
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Sequencer controls
  input  wire logic pll_resync,
  input  wire logic mgmt_ready,
  // Reference clock and loop lock
  output logic      ref_clk_in,
  output logic      tx_clk_valid,
  output logic      rx_clk_valid
);
  int lock_count;
  // Free running, phase offset from clk to avoid edge races
  initial begin
    ref_clk_in = 1'b0;
    #3;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  // Loops lock a while after resync and drop on any reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_count <= 0;
    end else if (!mgmt_ready) begin
      lock_count <= 0;
    end else if (pll_resync) begin
      lock_count <= LOCK_CYCLES;
    end else if (lock_count > 1) begin
      lock_count <= lock_count - 1;
    end
  end
  assign tx_clk_valid = (lock_count == 1);
  assign rx_clk_valid = (lock_count == 1);
endmodule

// ===== verif/phy_reset_powerdown_sequencer_test.sv
`timescale 1ns/10ps
module phy_reset_powerdown_sequencer_test
  import phy_reset_pkg::*;
;
  logic             clk = 1'b0, arst_n = 1'b0, supply_ok = 1'b1;
  logic             hard_reset_pin_low_active = 1'b1;
  logic [4:0]       addr_strap = 5'h13;
  logic             sw_reset_write = 1'b0, status_read = 1'b0;
  logic             power_down_write = 1'b0, power_down_wdata = 1'b0;
  latch_status_type status_live = 6'h20;
  logic             ref_clk_in, tx_clk_valid, rx_clk_valid;
  logic [15:0]      ctrl_reg, ext_ctrl_reg;
  latch_status_type status_latched;
  logic             mac_inputs_isolate, mac_outputs_enable, modules_enable;
  logic             line_transmit_enable, power_down, defaults_load;
  logic             pll_resync, mgmt_ready, mii_ready;
  int               fail_count = 0, total_checks = 0;

  always #4 clk = ~clk;
  // Hold shortened; expectations follow this value
  phy_reset_powerdown_sequencer #(.POR_CYCLES(100)) u_dut (
    .clk, .arst_n, .supply_ok, .ref_clk_in, .hard_reset_pin_low_active,
    .addr_strap, .sw_reset_write, .power_down_write, .power_down_wdata,
    .status_live, .status_read, .tx_clk_valid, .rx_clk_valid, .ctrl_reg,
    .ext_ctrl_reg, .status_latched, .mac_inputs_isolate,
    .mac_outputs_enable, .line_transmit_enable, .modules_enable,
    .power_down, .defaults_load, .pll_resync, .mgmt_ready, .mii_ready
  );
  phy_far_side_model u_far (
    .clk, .arst_n, .pll_resync, .mgmt_ready, .ref_clk_in, .tx_clk_valid,
    .rx_clk_valid
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic wait_mac(output int n);
    n = 0;
    while (mac_outputs_enable !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk1(mac_outputs_enable, 1'b1);
  endtask

  task automatic t_por();
    int n;
    repeat (10) @(negedge clk);
    hard_reset_pin_low_active = 1'b0;
    repeat (2) @(negedge clk);
    hard_reset_pin_low_active = 1'b1;
    repeat (40) @(negedge clk);
    chk1(power_down, 1'b1);
    wait_mac(n);
    chk1(n >= 48, 1'b1);
    chk(ext_ctrl_reg, 16'h04c0);
    chk(ctrl_reg, 16'h0000);
    repeat (100) @(negedge clk);
    chk1(mii_ready, 1'b1);
  endtask
  task automatic t_sw();
    int   n;
    logic prev;
    addr_strap = 5'h05;
    sw_reset_write = 1'b1;
    // Sampled before the write edge, so a rise just after it still counts
    prev = ref_clk_in;
    @(negedge clk);
    sw_reset_write = 1'b0;
    n = 0;
    chk(ctrl_reg, 16'h8000);
    chk1(power_down, 1'b0);
    chk1(mac_outputs_enable, 1'b0);
    while (ctrl_reg[15] === 1'b1 && n < 8) begin
      @(negedge clk);
      n += (ref_clk_in && !prev);
      prev = ref_clk_in;
    end
    chk(16'(n), 16'h0002);
    wait_mac(n);
    chk(ext_ctrl_reg, 16'h04c0);
  endtask
  task automatic t_pd();
    status_live = 6'h15;
    @(negedge clk);
    status_live = 6'h20;
    chk({10'h0, status_latched}, 16'h0015);
    power_down_write = 1'b1;
    power_down_wdata = 1'b1;
    @(negedge clk);
    power_down_write = 1'b0;
    @(negedge clk);
    chk1(power_down, 1'b1);
    chk1(line_transmit_enable, 1'b0);
    chk1(mac_outputs_enable, 1'b0);
    chk1(mgmt_ready, 1'b1);
    chk(ctrl_reg, 16'h0800);
    chk(ext_ctrl_reg, 16'h04c0);
    chk({10'h0, status_latched}, 16'h0020);
  endtask
  task automatic t_hw();
    int n;
    addr_strap = 5'h0a;
    hard_reset_pin_low_active = 1'b0;
    repeat (25) @(negedge clk);
    chk1(mac_inputs_isolate, 1'b1);
    chk1(mgmt_ready, 1'b0);
    chk1(power_down, 1'b1);
    hard_reset_pin_low_active = 1'b1;
    @(negedge clk);
    chk1(defaults_load, 1'b1);
    chk1(modules_enable, 1'b1);
    chk1(line_transmit_enable, 1'b1);
    chk1(mac_outputs_enable, 1'b0);
    @(negedge clk);
    chk1(pll_resync, 1'b1);
    chk1(mgmt_ready, 1'b1);
    chk1(defaults_load, 1'b0);
    wait_mac(n);
    chk1(n <= 80, 1'b1);
    chk(ctrl_reg, 16'h0000);
    chk(ext_ctrl_reg, 16'h0280);
    chk1(power_down, 1'b0);
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is a few microseconds
  initial begin
    #100us;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    t_por();
    t_sw();
    t_pd();
    t_hw();
    conclude();
  end
endmodule
